// ### hw/eeprom_protect_pkg.sv
package eeprom_protect_pkg;

	// ----------------------------------------------------------------
	// Geometry and instruction fields.
	// ----------------------------------------------------------------
	localparam int         ADDR_W           = 8;
	localparam int         WORD_W           = 16;
	localparam int         DEPTH            = 256;
	localparam int         PAGE_WORDS       = 4;
	localparam logic [3:0] CMD_LAST_BIT     = 4'h9;
	localparam logic [3:0] WORD_LAST_BIT    = 4'hF;
	localparam logic [4:0] WORD_BITS        = 5'h10;
	localparam logic [4:0] PROT_READ_BITS   = 5'h09;
	localparam logic [1:0] OP_READ          = 2'h2;
	localparam logic [1:0] OP_WRITE         = 2'h1;
	localparam logic [1:0] OP_PAGE          = 2'h3;
	localparam logic [1:0] OP_MISC          = 2'h0;
	localparam logic [1:0] MISC_LOCK        = 2'h0;
	localparam logic [1:0] MISC_FILL        = 2'h1;
	localparam logic [1:0] MISC_UNLOCK      = 2'h3;
	localparam logic [7:0] PROT_CLEAR_ADDR  = 8'hFF;
	localparam logic [7:0] PROT_FREEZE_ADDR = 8'h00;

	// ----------------------------------------------------------------
	// Values after reset.
	// ----------------------------------------------------------------
	localparam logic [15:0] WORD_RESET   = 16'hFFFF;
	localparam logic [7:0]  PROT_RESET   = 8'hFF;
	localparam logic        PFLAG_RESET  = 1'b1;
	localparam logic        PFLAG_ACTIVE = 1'b0;
	localparam logic        FREEZE_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Self-timed programming time.
	// ----------------------------------------------------------------
	localparam int PROG_TIME_NS    = 5000000;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 24;

	typedef struct packed {
		logic [1:0] opcode;
		logic [7:0] addr;
	} cmd_type;

	typedef enum logic [2:0] {
		P_IDLE = 3'b000,
		P_CMD  = 3'b001,
		P_DATA = 3'b010,
		P_OUT  = 3'b011,
		P_DONE = 3'b100
	} phase_type;

	typedef enum logic [2:0] {
		ACT_NONE   = 3'b000,
		ACT_WRITE  = 3'b001,
		ACT_PAGE   = 3'b010,
		ACT_FILL   = 3'b011,
		ACT_PBW    = 3'b100,
		ACT_PBC    = 3'b101,
		ACT_FREEZE = 3'b110
	} action_type;

endpackage

// ### hw/serial_eeprom_write_protect.sv
`timescale 1ns/10ps
// Contract
// - Words at or above the stored bound are refused programming while protection is active.
// - Protect-bound write clears the protect flag; the flag is readable afterwards.
// - Protect-bound clear loads all ones, sets the flag, re-enables word write and fill.
// - Protect-modifying instructions act only right after a protect-unlock.
// - Protect-bound write needs no earlier protect-bound clear.
// - Protect-unlock leaves the protect flag unchanged.
// - Protect-bound read shifts out a zero, the bound, then the flag.
// - Protect-freeze sets a freeze bit that only system reset clears, fixing the bound.
// - Once frozen, nothing may modify the bound.
// - Frozen: a protect-bound write shows no status; unfrozen: it shows busy.
// - During programming the output is low with select high and inputs are ignored.
// - After programming the output is high until a start bit or select falls.
// - Every word reads all ones as delivered.
// - Select rises, a one start bit, two opcode bits, eight address bits.
// - A single-word write programs only outside the protected area.
// - A page write is abandoned if any target word is protected.
module serial_eeprom_write_protect
	import eeprom_protect_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic CS,
	input  wire logic SCLK,
	input  wire logic DIN,
	input  wire logic PROT_EN,
	input  wire logic WR_EN,
	output logic      DOUT,
	output logic      DOUT_OE
);

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection.
	// ----------------------------------------------------------------
	logic [4:0]             pin_m;
	logic [4:0]             pin_s;
	logic [4:0]             pin_d;
	logic                   cs;
	logic                   din;
	logic                   pre;
	logic                   wr;
	logic                   clk_rise;
	logic                   cs_fall;

	phase_type              phase;
	action_type             action;
	cmd_type                cmd;
	cmd_type                next_cmd;
	logic [3:0]             bit_cnt;
	logic [15:0]            data_shift;
	logic [15:0]            page_buf [0:PAGE_WORDS-1];
	logic [2:0]             page_cnt;
	logic [7:0]             target;
	logic                   armed;
	logic                   commit;
	logic                   unlock;
	logic                   write_en;
	logic [15:0]            out_word;
	logic [4:0]             out_left;
	logic                   out_mem;
	logic [7:0]             rd_addr;
	logic                   shift_q;
	logic                   start_seen;

	logic [15:0]            mem [0:DEPTH-1];
	logic [7:0]             prot_reg;
	logic                   pflag;
	logic                   frozen;
	logic                   page_blocked;
	logic                   go;
	logic                   busy;
	logic [CNT_W-1:0]       prog_cnt;
	logic                   status_on;

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pin_m <= 5'h00;
			pin_s <= 5'h00;
			pin_d <= 5'h00;
		end
		else
		begin
			pin_m <= {CS, SCLK, DIN, PROT_EN, WR_EN};
			pin_s <= pin_m;
			pin_d <= pin_s;
		end
	end

	assign cs         = pin_s[4];
	assign din        = pin_s[2];
	assign pre        = pin_s[1];
	assign wr         = pin_s[0];
	assign clk_rise   = pin_s[3] & ~pin_d[3];
	assign cs_fall    = ~pin_s[4] & pin_d[4];
	assign next_cmd   = {cmd[8:0], din};
	assign start_seen = cs && clk_rise && !busy && (phase == P_IDLE) && din;

	function automatic logic protected_addr(input logic [7:0] a, input logic [7:0] bound,
		input logic flag);
		protected_addr = (flag == PFLAG_ACTIVE) && (a >= bound);
	endfunction

	function automatic logic [7:0] page_addr(input logic [7:0] base, input logic [1:0] i);
		page_addr = {base[7:2], base[1:0] + i};
	endfunction

	// ----------------------------------------------------------------
	// Serial front end: start bit, instruction decode, data in and out.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			phase      <= P_IDLE;
			action     <= ACT_NONE;
			cmd        <= '0;
			bit_cnt    <= 4'h0;
			data_shift <= 16'h0000;
			page_cnt   <= 3'h0;
			target     <= 8'h00;
			armed      <= 1'b0;
			commit     <= 1'b0;
			unlock     <= 1'b0;
			write_en   <= 1'b0;
			out_word   <= 16'h0000;
			out_left   <= 5'h00;
			out_mem    <= 1'b0;
			rd_addr    <= 8'h00;
			shift_q    <= 1'b0;
			for (int i = 0; i < PAGE_WORDS; i++)
				page_buf[i] <= 16'h0000;
		end
		else
		begin
			commit <= 1'b0;
			if (!cs)
			begin
				phase <= P_IDLE;
				armed <= 1'b0;
				if (cs_fall && armed)
					commit <= 1'b1;
			end
			else if (clk_rise && !busy)
			begin
				unique case (phase)
					P_IDLE:
					begin
						if (din)
						begin
							phase   <= P_CMD;
							bit_cnt <= 4'h0;
						end
					end
					P_CMD:
					begin
						cmd     <= next_cmd;
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == CMD_LAST_BIT)
						begin
							unlock   <= 1'b0;
							target   <= next_cmd.addr;
							action   <= ACT_NONE;
							phase    <= P_DONE;
							page_cnt <= 3'h0;
							bit_cnt  <= 4'h0;
							shift_q  <= 1'b0;
							if (pre)
							begin
								unique case (next_cmd.opcode)
									OP_READ:
									begin
										phase    <= P_OUT;
										out_word <= {prot_reg, pflag, 7'h00};
										out_left <= PROT_READ_BITS;
										out_mem  <= 1'b0;
									end
									OP_WRITE:
									begin
										if (wr && unlock && !frozen)
										begin
											action <= ACT_PBW;
											armed  <= 1'b1;
										end
									end
									OP_PAGE:
									begin
										if (wr && unlock && !frozen &&
											next_cmd.addr == PROT_CLEAR_ADDR)
										begin
											action <= ACT_PBC;
											armed  <= 1'b1;
										end
									end
									OP_MISC:
									begin
										if (next_cmd.addr[7:6] == MISC_UNLOCK && wr && write_en)
											unlock <= 1'b1;
										else if (next_cmd.addr == PROT_FREEZE_ADDR && wr && unlock &&
											!frozen)
										begin
											action <= ACT_FREEZE;
											armed  <= 1'b1;
										end
									end
								endcase
							end
							else
							begin
								unique case (next_cmd.opcode)
									OP_READ:
									begin
										phase    <= P_OUT;
										out_word <= mem[next_cmd.addr];
										out_left <= WORD_BITS;
										out_mem  <= 1'b1;
										rd_addr  <= next_cmd.addr;
									end
									OP_WRITE, OP_PAGE:
									begin
										if (wr && write_en)
										begin
											phase  <= P_DATA;
											action <= (next_cmd.opcode == OP_WRITE) ? ACT_WRITE : ACT_PAGE;
										end
									end
									OP_MISC:
									begin
										if (next_cmd.addr[7:6] == MISC_UNLOCK && wr)
											write_en <= 1'b1;
										else if (next_cmd.addr[7:6] == MISC_LOCK)
											write_en <= 1'b0;
										else if (next_cmd.addr[7:6] == MISC_FILL && wr && write_en &&
											pflag == PFLAG_RESET)
										begin
											phase  <= P_DATA;
											action <= ACT_FILL;
										end
									end
								endcase
							end
						end
					end
					P_DATA:
					begin
						data_shift <= {data_shift[14:0], din};
						bit_cnt    <= bit_cnt + 4'h1;
						if (bit_cnt == WORD_LAST_BIT)
						begin
							page_buf[page_cnt[1:0]] <= {data_shift[14:0], din};
							page_cnt                <= page_cnt + 3'h1;
							armed                   <= 1'b1;
							if (action != ACT_PAGE || page_cnt == 3'(PAGE_WORDS - 1))
								phase <= P_DONE;
						end
						else if (bit_cnt == 4'h0)
							armed <= 1'b0;
					end
					P_OUT:
					begin
						shift_q  <= out_word[15];
						out_word <= {out_word[14:0], 1'b0};
						if (out_left != 5'h00)
							out_left <= out_left - 5'h01;
						if (out_left == 5'h01 && out_mem)
						begin
							out_word <= mem[rd_addr + 8'h01];
							rd_addr  <= rd_addr + 8'h01;
							out_left <= WORD_BITS;
						end
					end
					P_DONE:
					begin
						armed <= 1'b0;
					end
					default:
					begin
						phase <= P_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Protection check on the collected write targets.
	// ----------------------------------------------------------------
	always_comb
	begin
		page_blocked = 1'b0;
		for (int i = 0; i < PAGE_WORDS; i++)
			if (3'(i) < page_cnt && protected_addr(page_addr(target, 2'(i)), prot_reg, pflag))
				page_blocked = 1'b1;
	end

	assign go = commit && !(action == ACT_WRITE && protected_addr(target, prot_reg, pflag)) &&
		!(action == ACT_PAGE && page_blocked);

	// ----------------------------------------------------------------
	// Memory array and protection state.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			prot_reg <= PROT_RESET;
			pflag    <= PFLAG_RESET;
			frozen   <= FREEZE_RESET;
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= WORD_RESET;
		end
		else if (go)
		begin
			unique case (action)
				ACT_WRITE:
					mem[target] <= page_buf[0];
				ACT_PAGE:
				begin
					for (int i = 0; i < PAGE_WORDS; i++)
						if (3'(i) < page_cnt)
							mem[page_addr(target, 2'(i))] <= page_buf[i];
				end
				ACT_FILL:
				begin
					for (int i = 0; i < DEPTH; i++)
						mem[i] <= page_buf[0];
				end
				ACT_PBW:
				begin
					prot_reg <= target;
					pflag    <= PFLAG_ACTIVE;
				end
				ACT_PBC:
				begin
					prot_reg <= PROT_CLEAR_ADDR;
					pflag    <= PFLAG_RESET;
				end
				ACT_FREEZE:
					frozen <= 1'b1;
				default:
				begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Self-timed programming and ready/busy status.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			busy     <= 1'b0;
			prog_cnt <= '0;
		end
		else if (go)
		begin
			busy     <= 1'b1;
			prog_cnt <= CNT_W'(PROG_CYCLES - 1);
		end
		else if (busy)
		begin
			if (prog_cnt == '0)
				busy <= 1'b0;
			else
				prog_cnt <= prog_cnt - 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			status_on <= 1'b0;
		else if (go)
			status_on <= 1'b1;
		else if (!busy && (cs_fall || start_seen))
			status_on <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Serial output pin.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			DOUT    <= 1'b0;
			DOUT_OE <= 1'b0;
		end
		else
		begin
			DOUT_OE <= cs;
			if (!cs)
				DOUT <= 1'b0;
			else if (status_on)
				DOUT <= !busy;
			else
				DOUT <= shift_q;
		end
	end

endmodule // serial_eeprom_write_protect

// ### bench/eeprom_protect_properties.sv
`timescale 1ns/10ps
module eeprom_protect_properties
	import eeprom_protect_pkg::*;
#(
	parameter int PROG_CYCLES = 40
)
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CS,
	input wire logic SCLK,
	input wire logic DIN,
	input wire logic DOUT,
	input wire logic DOUT_OE
);
	logic       sclk_q;
	logic       cs_q;
	logic       rise;
	logic [3:0] calm;
	logic [3:0] nbit;
	logic [1:0] op;
	int         low;
	assign rise = SCLK && !sclk_q;
	// ----------
	// Pin edges, calm time, instruction bits and low time.
	// ----------
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			sclk_q <= 1'h0;
			cs_q   <= 1'h0;
			calm   <= 4'h0;
		end
		else
		begin
			sclk_q <= SCLK;
			cs_q   <= CS;
			calm   <= (SCLK != sclk_q || CS != cs_q) ? 4'h0 : calm + {3'h0, !calm[3]};
		end
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			nbit <= 4'h0;
			op   <= 2'h0;
		end
		else if (!CS)
			nbit <= 4'h0;
		else if (rise && !(&nbit) && (nbit != 4'h0 || DIN))
		begin
			nbit <= nbit + 4'h1;
			if (nbit < 4'h3)
				op <= {op[0], DIN};
		end
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
			low <= 0;
		else
			low <= (calm[3] && DOUT_OE && !DOUT) ? low + 1 : 0;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_cs_held;
		$rose(CS) ##1 CS [*5];
	endsequence
	sequence s_ready;
		calm[3] && CS && $rose(DOUT);
	endsequence
	property p_oe_on;
		s_cs_held |-> DOUT_OE;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("drive off with select high");
	property p_oe_off;
		!CS [*5] |-> !DOUT_OE;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drive on with select low");
	property p_dout_off;
		!CS [*5] |-> !DOUT;
	endproperty
	a_dout_off: assert property (p_dout_off) else $error("output high, select low");
	property p_reset_idle;
		$fell(SYS_RST) |-> !DOUT && !DOUT_OE;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("output busy at reset");
	property p_no_fall;
		calm[3] |-> !$fell(DOUT);
	endproperty
	a_no_fall: assert property (p_no_fall) else $error("output fell on quiet bus");
	property p_ready_holds;
		s_ready |=> (DOUT || !calm[3]) [*8];
	endproperty
	a_ready_holds: assert property (p_ready_holds) else $error("ready not held");
	property p_dummy;
		rise && nbit == 4'hA && op == OP_READ |-> ##6 !DOUT;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy bit not zero");
	property p_busy_ends;
		low <= PROG_CYCLES + 16;
	endproperty
	a_busy_ends: assert property (p_busy_ends) else $error("busy too long");
endmodule // eeprom_protect_properties

bind serial_eeprom_write_protect eeprom_protect_properties #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
	.CLK(CLK), .SYS_RST(SYS_RST), .CS(CS), .SCLK(SCLK), .DIN(DIN),
	.DOUT(DOUT), .DOUT_OE(DOUT_OE)
);

// ### bench/eeprom_host_model.sv
`timescale 1ns/10ps
module eeprom_host_model
	import eeprom_protect_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        dout,
	output logic             cs,
	output logic             sclk,
	output logic             din,
	output logic             prot_en,
	output logic             wr_en,
	output logic [16:0]      res,
	output logic             res_stb
);
	initial
	begin
		cs      = 1'h0;
		sclk    = 1'h0;
		din     = 1'h0;
		prot_en = 1'h0;
		wr_en   = 1'h0;
		res     = 17'h0;
		res_stb = 1'h0;
	end
	// ----------
	// Bus tasks; one serial clock period is 8 system clocks.
	// ----------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic note(input logic [16:0] v);
		res     <= v;
		res_stb <= 1'h1;
		tick(1);
		res_stb <= 1'h0;
	endtask
	task automatic put(input logic b, output logic q);
		din  <= b;
		sclk <= 1'h0;
		tick(2);
		q = dout;
		tick(2);
		sclk <= 1'h1;
		tick(4);
	endtask
	task automatic frame(input cmd_type c, input logic pe, input logic we,
		input int nw, input logic [63:0] wd, input int nr);
		logic        q;
		logic [16:0] acc;
		acc = 17'h0;
		prot_en <= pe;
		wr_en   <= we;
		cs      <= 1'h1;
		tick(4);
		put(1'h1, q);
		for (int i = 9; i >= 0; i--)
			put(c[i], q);
		for (int i = nw - 1; i >= 0; i--)
			put(wd[i], q);
		for (int i = 0; i < nr; i++)
		begin
			put(1'($urandom), q);
			acc = {acc[15:0], q};
		end
		sclk <= 1'h0;
		tick(4);
		cs <= 1'h0;
		if (nr > 0)
			note(acc);
		tick(6);
	endtask
	task automatic status(input int n);
		cs <= 1'h1;
		tick(8);
		note({16'h0, dout});
		tick(n);
		note({16'h0, dout});
		cs <= 1'h0;
		tick(6);
	endtask
endmodule // eeprom_host_model

// ### bench/serial_eeprom_write_protect_bench.sv
`timescale 1ns/10ps
module serial_eeprom_write_protect_bench
	import eeprom_protect_pkg::*;
;
	localparam int PROG  = 40;
	localparam int LIMIT = 30000;
	logic        clk     = 1'h0;
	logic        sys_rst = 1'h1;
	logic        cs, sclk, din, prot_en, wr_en, dout, dout_oe, res_stb;
	logic [16:0] res;
	logic [16:0] expq[$];
	logic [7:0]  bnd;
	logic [15:0] wd;
	int          n_mismatch  = 0;
	int          check_count = 0;
	int          cyc         = 0;
	always #5 clk = ~clk;
	serial_eeprom_write_protect #(.PROG_CYCLES(PROG)) dut_u (
		.CLK(clk), .SYS_RST(sys_rst), .CS(cs), .SCLK(sclk), .DIN(din),
		.PROT_EN(prot_en), .WR_EN(wr_en), .DOUT(dout), .DOUT_OE(dout_oe)
	);
	eeprom_host_model host_u (
		.clk(clk), .dout(dout), .cs(cs), .sclk(sclk), .din(din), .prot_en(prot_en),
		.wr_en(wr_en), .res(res), .res_stb(res_stb)
	);
	task automatic wrap_up();
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp_res(input logic [16:0] e, input logic [16:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] serial result expected %h seen %h", e, g);
		end
	endtask
	always @(posedge clk)
		if (res_stb === 1'h1)
			cmp_res(expq.pop_front(), res);
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic op(input logic [1:0] o, input logic [7:0] a, input logic pe,
		input logic we, input int nw = 0, input logic [63:0] d = 64'h0);
		host_u.frame({o, a}, pe, we, nw, d, 0);
	endtask
	task automatic rd_prot(input logic [7:0] b, input logic f);
		expq.push_back({8'h00, b, f});
		host_u.frame({OP_READ, 8'h00}, 1'h1, 1'h0, 0, 64'h0, 10);
	endtask
	task automatic rd_word(input logic [7:0] a, input logic [15:0] v);
		expq.push_back({1'h0, v});
		host_u.frame({OP_READ, a}, 1'h0, 1'h0, 0, 64'h0, 17);
	endtask
	task automatic busy();
		expq.push_back(17'h0);
		expq.push_back(17'h1);
		host_u.status(PROG + 20);
	endtask
	task automatic no_status();
		expq.push_back(17'h0);
		expq.push_back(17'h0);
		host_u.status(8);
	endtask
	task automatic unlock();
		op(OP_MISC, 8'hC0, 1'h1, 1'h1);
	endtask
	// ----------
	// Scenarios.
	// ----------
	initial
	begin
		void'($urandom(6468));
		bnd = {6'($urandom), 2'h1};
		wd  = 16'($urandom);
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		host_u.tick(4);
		rd_prot(PROT_RESET, PFLAG_RESET);
		rd_word(8'h00, WORD_RESET);
		op(OP_MISC, 8'hC0, 1'h0, 1'h1);
		op(OP_WRITE, bnd, 1'h1, 1'h1);
		rd_prot(PROT_RESET, PFLAG_RESET);
		unlock();
		rd_prot(PROT_RESET, PFLAG_RESET);
		op(OP_WRITE, bnd, 1'h1, 1'h1);
		rd_prot(PROT_RESET, PFLAG_RESET);
		unlock();
		op(OP_WRITE, bnd, 1'h1, 1'h1);
		busy();
		rd_prot(bnd, PFLAG_ACTIVE);
		op(OP_WRITE, bnd, 1'h0, 1'h1, 16, {48'h0, ~wd});
		rd_word(bnd, WORD_RESET);
		op(OP_WRITE, bnd - 8'h1, 1'h0, 1'h1, 16, {48'h0, wd});
		busy();
		rd_word(bnd - 8'h1, wd);
		op(OP_PAGE, bnd - 8'h1, 1'h0, 1'h1, 64, {4{~wd}});
		rd_word(bnd - 8'h1, wd);
		op(OP_MISC, {MISC_FILL, 6'h00}, 1'h0, 1'h1, 16, {48'h0, ~wd});
		rd_word(bnd - 8'h1, wd);
		unlock();
		op(OP_PAGE, PROT_CLEAR_ADDR, 1'h1, 1'h1);
		host_u.tick(PROG + 20);
		rd_prot(PROT_RESET, PFLAG_RESET);
		op(OP_MISC, {MISC_FILL, 6'h00}, 1'h0, 1'h1, 16, {48'h0, ~wd});
		busy();
		rd_word(bnd + 8'h2, ~wd);
		op(OP_WRITE, bnd, 1'h0, 1'h1, 16, {48'h0, wd});
		busy();
		rd_word(bnd, wd);
		unlock();
		op(OP_WRITE, bnd, 1'h1, 1'h1);
		busy();
		unlock();
		op(OP_MISC, PROT_FREEZE_ADDR, 1'h1, 1'h1);
		host_u.tick(PROG + 20);
		unlock();
		op(OP_WRITE, 8'h10, 1'h1, 1'h1);
		host_u.tick(PROG + 20);
		no_status();
		rd_prot(bnd, PFLAG_ACTIVE);
		unlock();
		op(OP_PAGE, PROT_CLEAR_ADDR, 1'h1, 1'h1);
		rd_prot(bnd, PFLAG_ACTIVE);
		op(OP_MISC, 8'h00, 1'h0, 1'h1);
		op(OP_WRITE, 8'h00, 1'h0, 1'h1, 16, {48'h0, wd});
		rd_word(8'h00, ~wd);
		wrap_up();
	end
endmodule // serial_eeprom_write_protect_bench
